// file: src/wrf_pkg.sv
// shared constants and types for the watchdog with reset-cause flags
package wrf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          APB_AW          = 12;
  localparam logic [11:0] OFS_RST_CAUSE   = 12'h000;
  localparam logic [11:0] OFS_WD_CTL      = 12'h004;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  localparam logic [7:0]  RST_CAUSE_RESET = 8'h01;
  localparam logic [7:0]  RST_WR_MASK     = 8'h3f;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          WD_BASE_CYCLES  = 2048;
  localparam int          WD_CNT_W        = 20;
  localparam logic [3:0]  WD_MAX_SEL      = 4'h9;
  localparam logic [2:0]  CE_HOLD_CYCLES  = 3'h4;

  // ----------------------------------------------------------------
  // register layouts, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wd_irq_flag;
    logic       wd_irq_enable;
    logic       wd_prescale_hi;
    logic       wd_change_enable;
    logic       wd_reset_enable;
    logic [2:0] wd_prescale_lo;
  } wrf_ctl_s;

  typedef struct packed {
    logic [1:0] reserved;
    logic       usb_reset_flag;
    logic       jtag_reset_flag;
    logic       wd_reset_flag;
    logic       brownout_reset_flag;
    logic       pin_reset_flag;
    logic       poweron_reset_flag;
  } wrf_cause_s;

endpackage

// file: src/wrf_watchdog.sv
// watchdog timer with reset-cause status, apb register slave
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module wrf_watchdog
  import wrf_pkg::*;
#(
  parameter int TIMEOUT_BASE = wrf_pkg::WD_BASE_CYCLES
)
(
  // clock and power-on reset
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  // apb slave
  input  wire logic [wrf_pkg::APB_AW-1:0]  paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // watchdog oscillator and fuse pins
  input  wire logic                        wd_osc_i,
  input  wire logic                        wd_always_on_fuse_i,
  // processor core
  input  wire logic                        wd_restart_i,
  input  wire logic                        cpu_irq_global_en_i,
  input  wire logic                        wd_irq_ack_i,
  output logic                             wd_irq_o,
  output logic                             wd_reset_o,
  // other reset sources as one-cycle pulses, plus the usb reset enables
  input  wire logic                        pin_reset_i,
  input  wire logic                        brownout_reset_i,
  input  wire logic                        jtag_reset_i,
  input  wire logic                        usb_bus_reset_i,
  input  wire logic                        usb_enable_i,
  input  wire logic                        usb_cpu_reset_en_i
);

  import wrf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count before time-out; reserved codes fall back to the longest
  function automatic logic [WD_CNT_W-1:0] tmo_last(input logic [3:0] sel);
    logic [3:0]        idx;
    logic [WD_CNT_W:0] full;
    idx  = (sel > WD_MAX_SEL) ? WD_MAX_SEL : sel;
    full = (WD_CNT_W+1)'(TIMEOUT_BASE) << idx;
    return WD_CNT_W'(full - 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] osc_sync_q;
  logic [2:0] osc_sync_d;
  logic [1:0] fuse_sync_q;
  logic [1:0] fuse_sync_d;
  logic       osc_tick;
  logic       fuse_on;

  always_comb
  begin
    osc_sync_d  = {osc_sync_q[1:0], wd_osc_i};
    fuse_sync_d = {fuse_sync_q[0], wd_always_on_fuse_i};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      osc_sync_q  <= 3'h0;
      fuse_sync_q <= 2'h0;
    end
    else
    begin
      osc_sync_q  <= osc_sync_d;
      fuse_sync_q <= fuse_sync_d;
    end
  end

  // the oscillator is slow and free-running, so one tick per rising edge
  assign osc_tick = osc_sync_q[1] & ~osc_sync_q[2];
  assign fuse_on  = fuse_sync_q[1];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       hit_cause;
  logic       hit_ctl;
  logic       wr_cause;
  logic       wr_ctl;
  wrf_ctl_s   wr_val;

  assign hit_cause = (paddr_i == OFS_RST_CAUSE);
  assign hit_ctl   = (paddr_i == OFS_WD_CTL);
  assign acc       = psel_i & penable_i;
  assign wr_cause  = acc & pwrite_i & hit_cause;
  assign wr_ctl    = acc & pwrite_i & hit_ctl;
  assign wr_val    = wrf_ctl_s'(pwdata_i[7:0]);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~(hit_cause | hit_ctl);

  // ----------------------------------------------------------------
  // watchdog state
  // ----------------------------------------------------------------
  wrf_ctl_s            ctl_q;
  wrf_ctl_s            ctl_d;
  wrf_cause_s          cause_q;
  wrf_cause_s          cause_d;
  logic [WD_CNT_W-1:0] cnt_q;
  logic [WD_CNT_W-1:0] cnt_d;
  logic [2:0]          ce_cnt_q;
  logic [2:0]          ce_cnt_d;
  logic                pulse_q;
  logic                pulse_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;

  logic       wde_eff;
  logic       ie_eff;
  logic       running;
  logic       tmo;
  logic       wd_fire;
  logic       usb_evt;
  logic       sys_evt;
  logic [7:0] ctl_rd;

  // the reset flag and the fuse both hold reset-enable high
  assign wde_eff = ctl_q.wd_reset_enable | cause_q.wd_reset_flag
                 | fuse_on;
  assign ie_eff  = ctl_q.wd_irq_enable & ~fuse_on;
  assign running = wde_eff | ie_eff;
  assign tmo     = running & osc_tick
                 & (cnt_q == tmo_last({ctl_q.wd_prescale_hi,
                                       ctl_q.wd_prescale_lo}));
  // reset mode, or combined mode with the first interrupt unserviced
  assign wd_fire = tmo & wde_eff
                 & (~ie_eff | ctl_q.wd_irq_flag);
  assign usb_evt = usb_bus_reset_i & usb_enable_i
                 & usb_cpu_reset_en_i;
  assign sys_evt = wd_fire | pin_reset_i | brownout_reset_i
                 | jtag_reset_i | usb_evt;

  assign ctl_rd = {ctl_q.wd_irq_flag, ctl_q.wd_irq_enable,
                   ctl_q.wd_prescale_hi, ctl_q.wd_change_enable,
                   wde_eff, ctl_q.wd_prescale_lo};

  always_comb
  begin
    ctl_d    = ctl_q;
    cause_d  = cause_q;
    cnt_d    = cnt_q;
    ce_cnt_d = (ce_cnt_q != 3'h0) ? ce_cnt_q - 3'h1 : 3'h0;
    pulse_d  = wd_fire;
    prdata_d = prdata_q;

    // counter
    if (!running || wd_restart_i || tmo)
      cnt_d = '0;
    else if (osc_tick)
      cnt_d = cnt_q + 1'b1;

    // software writes to the control register
    if (wr_ctl)
    begin
      if (wr_val.wd_irq_flag)
        ctl_d.wd_irq_flag = 1'b0;
      ctl_d.wd_irq_enable = wr_val.wd_irq_enable;
      if (wr_val.wd_change_enable)
        ce_cnt_d = CE_HOLD_CYCLES;
      if (wr_val.wd_reset_enable)
        ctl_d.wd_reset_enable = 1'b1;
      else if (ctl_q.wd_change_enable && !cause_q.wd_reset_flag)
        ctl_d.wd_reset_enable = 1'b0;
      if (ctl_q.wd_change_enable)
      begin
        ctl_d.wd_prescale_hi = wr_val.wd_prescale_hi;
        ctl_d.wd_prescale_lo = wr_val.wd_prescale_lo;
      end
    end

    // vector execution
    if (wd_irq_ack_i)
    begin
      ctl_d.wd_irq_flag = 1'b0;
      if (wde_eff)
        ctl_d.wd_irq_enable = 1'b0;
    end

    // a time-out wins over a write-one or vector clear in the same cycle
    if (tmo && ie_eff)
      ctl_d.wd_irq_flag = 1'b1;

    // reset-cause register: writing zero clears, ones never set
    if (wr_cause)
      cause_d = wrf_cause_s'(8'(cause_q) & pwdata_i[7:0]
                             & RST_WR_MASK);
    if (jtag_reset_i)
      cause_d.jtag_reset_flag = 1'b1;
    if (usb_evt)
      cause_d.usb_reset_flag = 1'b1;
    if (wd_fire)
      cause_d.wd_reset_flag = 1'b1;
    if (brownout_reset_i)
      cause_d.brownout_reset_flag = 1'b1;
    if (pin_reset_i)
      cause_d.pin_reset_flag = 1'b1;
    cause_d.reserved = 2'h0;

    // any system reset returns the watchdog setup to its reset state
    if (sys_evt)
    begin
      ctl_d    = wrf_ctl_s'(CTL_RESET);
      ce_cnt_d = 3'h0;
      cnt_d    = '0;
    end

    if (fuse_on)
    begin
      ctl_d.wd_irq_enable   = 1'b0;
      ctl_d.wd_reset_enable = 1'b1;
    end
    ctl_d.wd_change_enable = (ce_cnt_d != 3'h0);

    // read data is captured in the setup cycle, so no wait states
    if (psel_i && !penable_i)
    begin
      if (hit_cause)
        prdata_d = {24'h0, 8'(cause_q)};
      else if (hit_ctl)
        prdata_d = {24'h0, ctl_rd};
      else
        prdata_d = 32'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_q    <= wrf_ctl_s'(CTL_RESET);
      cause_q  <= wrf_cause_s'(RST_CAUSE_RESET);
      cnt_q    <= '0;
      ce_cnt_q <= 3'h0;
      pulse_q  <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      ctl_q    <= ctl_d;
      cause_q  <= cause_d;
      cnt_q    <= cnt_d;
      ce_cnt_q <= ce_cnt_d;
      pulse_q  <= pulse_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o   = prdata_q;
  assign wd_reset_o = pulse_q;
  assign wd_irq_o   = ctl_q.wd_irq_flag & ie_eff
                    & cpu_irq_global_en_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic ce_wr;
  assign ce_wr = wr_ctl & wr_val.wd_change_enable;

  ce_clear_a:
  assert property ($rose(ctl_q.wd_change_enable) ##0 (!ce_wr)[*3]
                   |=> ctl_q.wd_change_enable ##1 !ctl_q.wd_change_enable)
    else $error("change enable did not clear after four clocks");

  prescale_lock_a:
  assert property (wr_ctl && !ctl_q.wd_change_enable && !sys_evt
                   |=> ctl_q.wd_prescale_lo == $past(ctl_q.wd_prescale_lo)
                       && ctl_q.wd_prescale_hi
                          == $past(ctl_q.wd_prescale_hi))
    else $error("prescaler changed without change enable");

  wde_held_a:
  assert property (cause_q.wd_reset_flag |-> ctl_rd[3])
    else $error("reset enable reads clear while reset flag set");

  fuse_mode_a:
  assert property (fuse_on |-> ##1 (wde_eff && !ctl_q.wd_irq_enable))
    else $error("fuse did not force system reset mode");

  irq_gate_a:
  assert property (wd_irq_o |-> ctl_q.wd_irq_flag && ctl_q.wd_irq_enable
                               && cpu_irq_global_en_i)
    else $error("interrupt raised without enables and flag");

  flag_set_a:
  assert property (tmo && ie_eff && !wde_eff && !sys_evt
                   |=> ctl_q.wd_irq_flag && !wd_reset_o)
    else $error("interrupt mode time-out did not set flag");

  ack_clear_a:
  assert property (wd_irq_ack_i && ie_eff && wde_eff && !tmo && !wr_ctl
                   |=> !ctl_q.wd_irq_enable && !ctl_q.wd_irq_flag)
    else $error("vector did not drop to system reset mode");

  second_tmo_a:
  assert property (tmo && ie_eff && wde_eff && ctl_q.wd_irq_flag
                   |=> wd_reset_o && cause_q.wd_reset_flag
                   ##1 !wd_reset_o)
    else $error("unserviced time-out gave no one-cycle reset");

  restart_a:
  assert property (wd_restart_i |=> cnt_q == '0)
    else $error("restart did not zero the counter");

  cause_rsvd_a:
  assert property (cause_q.reserved == 2'h0)
    else $error("reserved status bits set");

  por_keep_a:
  assert property (!(wr_cause && !pwdata_i[0])
                   |=> cause_q.poweron_reset_flag
                       == $past(cause_q.poweron_reset_flag))
    else $error("power-on flag changed without a zero write");

  flag_w1c_a:
  assert property (wr_ctl && wr_val.wd_irq_flag && !tmo
                   |=> !ctl_q.wd_irq_flag)
    else $error("writing one did not clear the interrupt flag");

  pin_flag_a:
  assert property (pin_reset_i |=> cause_q.pin_reset_flag)
    else $error("pin reset did not set its status flag");

endmodule

`default_nettype wire

// file: verification/wrf_watchdog_bench.sv
// self-checking bench for the watchdog with reset-cause flags
`timescale 1ns/1ps
`default_nettype none

module watchdog_with_reset_flags_bench;
  import wrf_pkg::*;

  // short base count keeps the ten prescaler runs brief
  localparam int TB = 4;

  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        wd_osc_i = 1'b0;
  logic        fuse_i = 1'b0;
  logic        wd_restart_i = 1'b0;
  logic        gie_i = 1'b0;
  logic        wd_irq_ack_i = 1'b0;
  logic        wd_irq_o;
  logic        wd_reset_o;
  logic        pin_i = 1'b0;
  logic        bod_i = 1'b0;
  logic        jtag_i = 1'b0;
  logic        usb_i = 1'b0;
  logic        usb_en_i = 1'b0;
  logic        usb_cre_i = 1'b0;
  logic [31:0] rd;
  logic        last_err;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_rst = 0;

  wrf_watchdog #(.TIMEOUT_BASE(TB)) uut (
    .mclk_i              (mclk_i),
    .reset_n_i           (reset_n_i),
    .paddr_i             (paddr_i),
    .psel_i              (psel_i),
    .penable_i           (penable_i),
    .pwrite_i            (pwrite_i),
    .pwdata_i            (pwdata_i),
    .prdata_o            (prdata_o),
    .pready_o            (pready_o),
    .pslverr_o           (pslverr_o),
    .wd_osc_i            (wd_osc_i),
    .wd_always_on_fuse_i (fuse_i),
    .wd_restart_i        (wd_restart_i),
    .cpu_irq_global_en_i (gie_i),
    .wd_irq_ack_i        (wd_irq_ack_i),
    .wd_irq_o            (wd_irq_o),
    .wd_reset_o          (wd_reset_o),
    .pin_reset_i         (pin_i),
    .brownout_reset_i    (bod_i),
    .jtag_reset_i        (jtag_i),
    .usb_bus_reset_i     (usb_i),
    .usb_enable_i        (usb_en_i),
    .usb_cpu_reset_en_i  (usb_cre_i)
  );

  always #10 mclk_i = ~mclk_i;

  // reset output is a one-cycle pulse, so each high cycle is one reset
  always @(posedge mclk_i)
    if (wd_reset_o === 1'b1)
      n_rst++;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= wr;
    pwdata_i <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // the wait ends once pready_o is high; the bench watchdog catches a hang
    do
    begin
      @(posedge mclk_i);
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  // timed sequence: change-enable with reset-enable, then the new value
  task automatic timed(input logic [7:0] v);
    apb(1'b1, OFS_WD_CTL, 8'h18);
    apb(1'b1, OFS_WD_CTL, v);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      wd_osc_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      wd_osc_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge mclk_i);
    case (k)
      0: pin_i <= 1'b1;
      1: bod_i <= 1'b1;
      2: jtag_i <= 1'b1;
      3: usb_i <= 1'b1;
      4: wd_restart_i <= 1'b1;
      default: wd_irq_ack_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    {pin_i, bod_i, jtag_i, usb_i, wd_restart_i, wd_irq_ack_i} <= 6'h00;
  endtask

  task automatic t_reset;
    rdchk("cause", OFS_RST_CAUSE, 8'h01);
    rdchk("ctl", OFS_WD_CTL, 8'h00);
    apb(1'b0, 12'h008, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, last_err});
    chk("unmapped data", 32'h0, rd);
    chk("ready", 32'h1, {31'h0, pready_o});
    $display("done reset values");
  endtask

  task automatic t_causes;
    pulse(0);
    rdchk("pin", OFS_RST_CAUSE, 8'h03);
    pulse(1);
    rdchk("bod", OFS_RST_CAUSE, 8'h07);
    pulse(2);
    rdchk("jtag", OFS_RST_CAUSE, 8'h17);
    pulse(3);
    rdchk("usb off", OFS_RST_CAUSE, 8'h17);
    @(posedge mclk_i);
    usb_en_i <= 1'b1;
    usb_cre_i <= 1'b1;
    pulse(3);
    rdchk("usb", OFS_RST_CAUSE, 8'h37);
    apb(1'b1, OFS_RST_CAUSE, 8'h3e);
    rdchk("por clr", OFS_RST_CAUSE, 8'h36);
    apb(1'b1, OFS_RST_CAUSE, 8'hff);
    rdchk("ones", OFS_RST_CAUSE, 8'h36);
    apb(1'b1, OFS_RST_CAUSE, 8'h00);
    rdchk("all clr", OFS_RST_CAUSE, 8'h00);
    $display("done reset causes");
  endtask

  task automatic t_change;
    apb(1'b1, OFS_WD_CTL, 8'h18);
    rdchk("ce set", OFS_WD_CTL, 8'h18);
    repeat (6) @(posedge mclk_i);
    rdchk("ce gone", OFS_WD_CTL, 8'h08);
    apb(1'b1, OFS_WD_CTL, 8'h0d);
    rdchk("no ce", OFS_WD_CTL, 8'h08);
    timed(8'h00);
    rdchk("timed", OFS_WD_CTL, 8'h00);
    $display("done change enable");
  endtask

  task automatic t_irq;
    apb(1'b1, OFS_WD_CTL, 8'h40);
    pulse(4);
    ticks(TB - 1);
    pulse(4);
    ticks(TB - 1);
    rdchk("restart", OFS_WD_CTL, 8'h40);
    ticks(1);
    rdchk("flag", OFS_WD_CTL, 8'hc0);
    chk("irq gie off", 32'h0, {31'h0, wd_irq_o});
    @(posedge mclk_i);
    gie_i <= 1'b1;
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk("irq on", 32'h1, {31'h0, wd_irq_o});
    apb(1'b1, OFS_WD_CTL, 8'hc0);
    rdchk("w1c", OFS_WD_CTL, 8'h40);
    chk("irq off", 32'h0, {31'h0, wd_irq_o});
    ticks(TB);
    pulse(5);
    rdchk("ack", OFS_WD_CTL, 8'h40);
    apb(1'b1, OFS_WD_CTL, 8'h00);
    ticks(2 * TB);
    rdchk("stopped", OFS_WD_CTL, 8'h00);
    chk("no reset", 32'h0, n_rst);
    $display("done interrupt mode");
  endtask

  task automatic t_comb;
    apb(1'b1, OFS_WD_CTL, 8'h48);
    pulse(4);
    ticks(TB);
    rdchk("comb flag", OFS_WD_CTL, 8'hc8);
    pulse(5);
    rdchk("vector", OFS_WD_CTL, 8'h08);
    ticks(TB);
    chk("reset mode", 32'h1, n_rst);
    rdchk("wd flag", OFS_RST_CAUSE, 8'h08);
    timed(8'h00);
    rdchk("re held", OFS_WD_CTL, 8'h08);
    apb(1'b1, OFS_RST_CAUSE, 8'h00);
    timed(8'h00);
    rdchk("re clr", OFS_WD_CTL, 8'h00);
    apb(1'b1, OFS_WD_CTL, 8'h48);
    pulse(4);
    ticks(2 * TB);
    chk("unserviced", 32'h2, n_rst);
    apb(1'b1, OFS_RST_CAUSE, 8'h00);
    timed(8'h00);
    $display("done combined mode");
  endtask

  task automatic t_presc;
    logic [7:0] v;
    for (int k = 0; k < 10; k++)
    begin
      v = {2'b01, 1'(k >> 3), 2'b00, 3'(k)};
      pulse(4);
      timed(v);
      ticks((TB << k) - 1);
      rdchk("early", OFS_WD_CTL, v);
      ticks(1);
      rdchk("timeout", OFS_WD_CTL, v | 8'h80);
      apb(1'b1, OFS_WD_CTL, v | 8'h80);
    end
    $display("done prescaler");
  endtask

  task automatic t_fuse;
    @(posedge mclk_i);
    fuse_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rdchk("fuse", OFS_WD_CTL, 8'h29);
    apb(1'b1, OFS_WD_CTL, 8'h40);
    rdchk("fuse lock", OFS_WD_CTL, 8'h29);
    timed(8'h40);
    rdchk("fuse timed", OFS_WD_CTL, 8'h08);
    pulse(4);
    ticks(TB);
    chk("fuse reset", 32'h3, n_rst);
    $display("done fuse");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    // the whole run needs about 40000 clocks, mostly the prescaler sweep
    repeat (60000) @(posedge mclk_i);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_causes();
    t_change();
    t_irq();
    t_comb();
    t_presc();
    t_fuse();
    close_out();
  end

endmodule
`default_nettype wire
